// [inc/ballast_consts.svh]
// constants for the ballast mode sequencer: field positions, counts
// assumes inclusion by bare name from the design files
`ifndef BALLAST_CONSTS_SVH
`define BALLAST_CONSTS_SVH

// ****************************************************************
// comparator bundle bit positions
// ****************************************************************
`define CMP_WIDTH          11
`define CMP_SUPPLY_ON      0
`define CMP_SUPPLY_OFF     1
`define CMP_LAMP_ABOVE_5V  2
`define CMP_LAMP_BELOW_3V  3
`define CMP_LAMP_BELOW_1V  4
`define CMP_PREHEAT_END    5
`define CMP_RUN_LEVEL      6
`define CMP_BUS_UNDER      7
`define CMP_OVERCURRENT    8
`define CMP_CT_UPPER       9
`define CMP_CT_LOWER       10

// ****************************************************************
// fault event counter
// ****************************************************************
`define EVENT_COUNT_WIDTH  7
`define EVENT_TRIP_COUNT   7'h64
`define EVENT_COUNT_ZERO   7'h00
`define EVENT_COUNT_ONE    7'h01

`endif

// [inc/ballast_pkg.sv]
// types shared by the ballast mode sequencer files
// assumes ballast_consts.svh on the include path
package ballast_pkg;

  // ****************************************************************
  // operating modes
  // ****************************************************************
  typedef enum logic [2:0] {
    SUPPLY_LOCKOUT = 3'h0,
    PREHEAT        = 3'h1,
    IGNITION       = 3'h2,
    RUN            = 3'h3,
    FAULT          = 3'h4
  } mode_state_type;

  // ****************************************************************
  // oscillator half-period phase
  // ****************************************************************
  typedef enum logic {
    DISCHARGE = 1'b0,
    CHARGE    = 1'b1
  } osc_phase_type;

endpackage

// [hdl/comparator_sync.sv]
// two-flop synchroniser for a bundle of comparator levels
// assumes levels arrive asynchronous to ref_clk_in
`timescale 1ns/1ps
module comparator_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // ****************************************************************
  // per-bit two-stage chain
  // ****************************************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      meta_d[i] = raw_in[i];
      sync_d[i] = meta_q[i];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule // comparator_sync

// [hdl/fault_event_counter.sv]
// up/down over-current event counter, stepped once per low-side cycle
// assumes step_in is a one-cycle pulse from the sequencer
`timescale 1ns/1ps
`include "ballast_consts.svh"
module fault_event_counter (
  input  wire logic                          ref_clk_in,
  input  wire logic                          reset_n_in,
  input  wire logic                          clear_in,
  input  wire logic                          enable_in,
  input  wire logic                          step_in,
  input  wire logic                          event_in,
  output logic                               trip_out,
  output logic [`EVENT_COUNT_WIDTH-1:0]      count_out
);

  logic [`EVENT_COUNT_WIDTH-1:0] count_q;
  logic [`EVENT_COUNT_WIDTH-1:0] count_d;
  logic                          trip_q;
  logic                          trip_d;

  // ****************************************************************
  // count up on event, down to zero without
  // ****************************************************************
  always_comb begin
    count_d = count_q;
    if (clear_in) begin
      count_d = `EVENT_COUNT_ZERO; // R23
    end else if (enable_in && step_in) begin // R13
      if (event_in) begin // R09
        if (count_q != `EVENT_TRIP_COUNT) begin
          count_d = count_q + `EVENT_COUNT_ONE; // R10
        end
      end else if (count_q != `EVENT_COUNT_ZERO) begin
        count_d = count_q - `EVENT_COUNT_ONE; // R12
      end
    end
    trip_d = !clear_in && (count_d == `EVENT_TRIP_COUNT); // R10
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      count_q <= `EVENT_COUNT_ZERO;
      trip_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      trip_q  <= trip_d;
    end
  end

  assign trip_out  = trip_q;
  assign count_out = count_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_count_floor: assert property (@(posedge ref_clk_in) // R12
    disable iff (!reset_n_in)
    enable_in && step_in && !event_in && !clear_in
      && count_q == `EVENT_COUNT_ZERO |=> count_q == `EVENT_COUNT_ZERO)
    else $error("event count went below zero");

  chk_count_step_up: assert property (@(posedge ref_clk_in) // R10
    disable iff (!reset_n_in)
    enable_in && step_in && event_in && !clear_in
      && count_q != `EVENT_TRIP_COUNT
      |=> count_q == $past(count_q) + `EVENT_COUNT_ONE)
    else $error("event count did not step up");

  chk_count_idle: assert property (@(posedge ref_clk_in) // R13
    disable iff (!reset_n_in)
    !enable_in && !clear_in |=> $stable(count_q))
    else $error("event count moved while disabled");

endmodule // fault_event_counter

// [hdl/ballast_mode_sequencer.sv]
// ballast mode sequencer: lockout, preheat, ignition, run, fault
// assumes digitised comparator levels from the analog front end
//
// Contract
// [R01] lockout: gates low, timing cap and preheat node clamped to ground
// [R02] leave lockout only with supply on and lamp sense below 3.0 V
// [R03] first gate pulse after lockout is low side
// [R04] preheat alternates high and low gates, 50% duty with deadtime
// [R05] charge phase one gate on; discharge phase both off as deadtime
// [R06] preheat entry releases preheat node, 3.6 uA source charges it
// [R07] preheat to ignition once preheat node exceeds 10.8 V
// [R08] over-current and bus undervoltage reset enabled above 12 V
// [R09] current sense above 1.20 V registers an over-current event
// [R10] preheat/ignition: fault after 100 consecutive low-side events
// [R11] count an event only during low-side on-time
// [R12] cycle without event decrements counter, floor at zero
// [R13] event counter active in preheat and ignition, not run
// [R14] run: first single over-current event enters fault
// [R15] run: lamp sense above 3.0 V or below 1.0 V enters fault
// [R16] fault latches high, low and boost gates low
// [R17] fault entry clamps preheat node to ground
// [R18] fault exits to lockout on supply off or lamp sense above 5 V
// [R19] after fault, restart needs lamp above 5 V then below 3 V
// [R20] bus sense below 3.0 V discharges supply, gates latched low
// [R21] preheat node above 12.0 V establishes run
// [R22] every comparator level synchronised before use
// [R23] lockout clears the event counter
`timescale 1ns/1ps
`include "ballast_consts.svh"
module ballast_mode_sequencer
  import ballast_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic reset_n_in,
  input  wire logic supply_on_in,
  input  wire logic supply_off_in,
  input  wire logic lamp_above_5v_in,
  input  wire logic lamp_below_3v_in,
  input  wire logic lamp_below_1v_in,
  input  wire logic preheat_end_threshold_in,
  input  wire logic run_threshold_in,
  input  wire logic bus_undervoltage_threshold_in,
  input  wire logic overcurrent_threshold_in,
  input  wire logic timing_cap_upper_in,
  input  wire logic timing_cap_lower_in,
  output logic      high_side_gate_out,
  output logic      low_side_gate_out,
  output logic      boost_switch_gate_out,
  output logic      timing_cap_node_clamp_out,
  output logic      preheat_timer_node_clamp_out,
  output logic      preheat_source_enable_out,
  output logic      supply_discharge_out,
  output logic      fault_mode_out
);

  // ****************************************************************
  // decoding helpers
  // ****************************************************************
  function automatic logic is_oscillating(input mode_state_type s);
    return (s == PREHEAT) || (s == IGNITION) || (s == RUN);
  endfunction

  function automatic logic is_counting(input mode_state_type s);
    return (s == PREHEAT) || (s == IGNITION);
  endfunction

  // ****************************************************************
  // comparator synchronisation
  // ****************************************************************
  logic [`CMP_WIDTH-1:0] cmp_raw;
  logic [`CMP_WIDTH-1:0] cmp_s;
  logic                  supply_on_s;
  logic                  supply_off_s;
  logic                  lamp_above_5v_s;
  logic                  lamp_below_3v_s;
  logic                  lamp_below_1v_s;
  logic                  preheat_end_s;
  logic                  run_level_s;
  logic                  bus_under_s;
  logic                  overcurrent_s;
  logic                  ct_upper_s;
  logic                  ct_lower_s;

  always_comb begin
    cmp_raw                     = '0;
    cmp_raw[`CMP_SUPPLY_ON]     = supply_on_in;
    cmp_raw[`CMP_SUPPLY_OFF]    = supply_off_in;
    cmp_raw[`CMP_LAMP_ABOVE_5V] = lamp_above_5v_in;
    cmp_raw[`CMP_LAMP_BELOW_3V] = lamp_below_3v_in;
    cmp_raw[`CMP_LAMP_BELOW_1V] = lamp_below_1v_in;
    cmp_raw[`CMP_PREHEAT_END]   = preheat_end_threshold_in;
    cmp_raw[`CMP_RUN_LEVEL]     = run_threshold_in;
    cmp_raw[`CMP_BUS_UNDER]     = bus_undervoltage_threshold_in;
    cmp_raw[`CMP_OVERCURRENT]   = overcurrent_threshold_in;
    cmp_raw[`CMP_CT_UPPER]      = timing_cap_upper_in;
    cmp_raw[`CMP_CT_LOWER]      = timing_cap_lower_in;
  end

  comparator_sync #(.WIDTH(`CMP_WIDTH)) u_sync ( // R22
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .raw_in     (cmp_raw),
    .sync_out   (cmp_s)
  );

  assign supply_on_s     = cmp_s[`CMP_SUPPLY_ON];
  assign supply_off_s    = cmp_s[`CMP_SUPPLY_OFF];
  assign lamp_above_5v_s = cmp_s[`CMP_LAMP_ABOVE_5V];
  assign lamp_below_3v_s = cmp_s[`CMP_LAMP_BELOW_3V];
  assign lamp_below_1v_s = cmp_s[`CMP_LAMP_BELOW_1V];
  assign preheat_end_s   = cmp_s[`CMP_PREHEAT_END];
  assign run_level_s     = cmp_s[`CMP_RUN_LEVEL];
  assign bus_under_s     = cmp_s[`CMP_BUS_UNDER];
  assign overcurrent_s   = cmp_s[`CMP_OVERCURRENT];
  assign ct_upper_s      = cmp_s[`CMP_CT_UPPER];
  assign ct_lower_s      = cmp_s[`CMP_CT_LOWER];

  // ****************************************************************
  // state and oscillator registers
  // ****************************************************************
  mode_state_type state_q;
  mode_state_type state_d;
  osc_phase_type  phase_q;
  osc_phase_type  phase_d;
  logic           side_high_q;
  logic           side_high_d;
  logic           prot_en_q;
  logic           prot_en_d;
  logic           rearm_q;
  logic           rearm_d;
  logic           discharge_q;
  logic           discharge_d;
  logic           oc_seen_q;
  logic           oc_seen_d;
  logic           low_step;
  logic           low_event;
  logic           ls_on_time;
  logic           bus_trip;
  logic           count_trip;

  assign ls_on_time = is_oscillating(state_q) && (phase_q == CHARGE)
                      && !side_high_q;
  assign low_step   = ls_on_time && ct_upper_s;
  assign low_event  = oc_seen_q || (ls_on_time && overcurrent_s); // R11
  assign bus_trip   = prot_en_q && bus_under_s; // R08

  // ****************************************************************
  // mode transitions
  // ****************************************************************
  always_comb begin
    state_d     = state_q;
    prot_en_d   = prot_en_q;
    rearm_d     = rearm_q;
    discharge_d = discharge_q;
    case (state_q)
      SUPPLY_LOCKOUT: begin
        prot_en_d = 1'b0;
        if (supply_on_s && lamp_below_3v_s && !discharge_q
            && !rearm_q) begin // R02 R19
          state_d = PREHEAT;
        end
      end
      PREHEAT: begin
        if (preheat_end_s) begin
          state_d = IGNITION; // R07
        end
      end
      IGNITION: begin
        if (run_level_s) begin
          state_d = RUN; // R21
        end
      end
      RUN: begin
        if (overcurrent_s) begin
          state_d = FAULT; // R14
        end else if (!lamp_below_3v_s || lamp_below_1v_s) begin
          state_d = FAULT; // R15
        end
      end
      FAULT: begin
        prot_en_d = 1'b0;
        if (supply_off_s || lamp_above_5v_s) begin
          state_d = SUPPLY_LOCKOUT; // R18
        end
      end
      default: begin
        state_d = SUPPLY_LOCKOUT;
      end
    endcase
    if (is_counting(state_q) && count_trip) begin
      state_d = FAULT; // R10
    end
    if (is_oscillating(state_q) && run_level_s) begin
      prot_en_d = 1'b1; // R08
    end
    if (is_oscillating(state_q) && bus_trip) begin
      state_d = SUPPLY_LOCKOUT; // R20
    end
    if (is_oscillating(state_q) && supply_off_s) begin
      state_d = SUPPLY_LOCKOUT;
    end
    // supply discharge held until supply falls past turn-off
    if (supply_off_s) begin
      discharge_d = 1'b0;
    end
    if (is_oscillating(state_q) && bus_trip) begin
      discharge_d = 1'b1; // R20
    end
    // restart blocked after fault until lamp sense passes 5 V
    if (lamp_above_5v_s) begin
      rearm_d = 1'b0; // R19
    end
    if (state_d == FAULT) begin
      rearm_d = 1'b1; // R19
    end
  end

  // ****************************************************************
  // oscillator phase and side
  // ****************************************************************
  always_comb begin
    phase_d     = phase_q;
    side_high_d = side_high_q;
    oc_seen_d   = oc_seen_q;
    if (!is_oscillating(state_d)) begin
      phase_d     = CHARGE;
      side_high_d = 1'b0; // R03
      oc_seen_d   = 1'b0;
    end else begin
      if ((phase_q == CHARGE) && ct_upper_s) begin
        phase_d = DISCHARGE; // R05
      end else if ((phase_q == DISCHARGE) && ct_lower_s) begin
        phase_d     = CHARGE;
        side_high_d = !side_high_q; // R04
      end
      if (low_step) begin
        oc_seen_d = 1'b0;
      end else if (ls_on_time && overcurrent_s) begin
        oc_seen_d = 1'b1; // R09 R11
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      state_q     <= SUPPLY_LOCKOUT;
      phase_q     <= CHARGE;
      side_high_q <= 1'b0;
      prot_en_q   <= 1'b0;
      rearm_q     <= 1'b0;
      discharge_q <= 1'b0;
      oc_seen_q   <= 1'b0;
    end else begin
      state_q     <= state_d;
      phase_q     <= phase_d;
      side_high_q <= side_high_d;
      prot_en_q   <= prot_en_d;
      rearm_q     <= rearm_d;
      discharge_q <= discharge_d;
      oc_seen_q   <= oc_seen_d;
    end
  end

  // ****************************************************************
  // over-current event counter
  // ****************************************************************
  fault_event_counter u_counter (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .clear_in   (state_q == SUPPLY_LOCKOUT), // R23
    .enable_in  (is_counting(state_q)), // R13
    .step_in    (low_step),
    .event_in   (low_event),
    .trip_out   (count_trip),
    .count_out  ()
  );

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  logic hs_q;
  logic hs_d;
  logic ls_q;
  logic ls_d;
  logic boost_q;
  logic boost_d;
  logic ct_clamp_q;
  logic ct_clamp_d;
  logic cph_clamp_q;
  logic cph_clamp_d;
  logic dis_q;
  logic dis_d;
  logic fault_q;
  logic fault_d;
  logic src_q;
  logic src_d;

  always_comb begin
    hs_d        = is_oscillating(state_d) && (phase_d == CHARGE)
                  && side_high_d; // R04 R05
    ls_d        = is_oscillating(state_d) && (phase_d == CHARGE)
                  && !side_high_d; // R03 R05
    boost_d     = is_oscillating(state_d); // R16
    ct_clamp_d  = !is_oscillating(state_d); // R01
    cph_clamp_d = !is_oscillating(state_d); // R01 R06 R17
    src_d       = is_oscillating(state_d); // R06
    dis_d       = discharge_d; // R20
    fault_d     = (state_d == FAULT);
  end

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      hs_q        <= 1'b0;
      ls_q        <= 1'b0;
      boost_q     <= 1'b0;
      ct_clamp_q  <= 1'b1;
      cph_clamp_q <= 1'b1;
      dis_q       <= 1'b0;
      fault_q     <= 1'b0;
      src_q       <= 1'b0;
    end else begin
      hs_q        <= hs_d;
      ls_q        <= ls_d;
      boost_q     <= boost_d;
      ct_clamp_q  <= ct_clamp_d;
      cph_clamp_q <= cph_clamp_d;
      dis_q       <= dis_d;
      fault_q     <= fault_d;
      src_q       <= src_d;
    end
  end

  assign high_side_gate_out           = hs_q;
  assign low_side_gate_out            = ls_q;
  assign boost_switch_gate_out        = boost_q;
  assign timing_cap_node_clamp_out    = ct_clamp_q;
  assign preheat_timer_node_clamp_out = cph_clamp_q;
  assign preheat_source_enable_out    = src_q;
  assign supply_discharge_out         = dis_q;
  assign fault_mode_out               = fault_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_lockout_outputs_low: assert property (@(posedge ref_clk_in) // R01
    disable iff (!reset_n_in)
    state_q == SUPPLY_LOCKOUT |-> !hs_q && !ls_q && ct_clamp_q
      && cph_clamp_q)
    else $error("lockout outputs not held");

  chk_lockout_exit_cond: assert property (@(posedge ref_clk_in) // R02
    disable iff (!reset_n_in)
    state_q == SUPPLY_LOCKOUT ##1 state_q == PREHEAT
      |-> $past(supply_on_s) && $past(lamp_below_3v_s))
    else $error("lockout left without start condition");

  chk_first_pulse_low: assert property (@(posedge ref_clk_in) // R03
    disable iff (!reset_n_in)
    state_q == SUPPLY_LOCKOUT ##1 state_q == PREHEAT
      |-> ls_q && !hs_q)
    else $error("first pulse not on low side");

  chk_gates_exclusive: assert property (@(posedge ref_clk_in) // R04
    disable iff (!reset_n_in)
    !(hs_q && ls_q))
    else $error("both gates on");

  chk_deadtime_gap: assert property (@(posedge ref_clk_in) // R05
    disable iff (!reset_n_in)
    phase_q == DISCHARGE |-> !hs_q && !ls_q)
    else $error("gate on during deadtime");

  chk_preheat_end: assert property (@(posedge ref_clk_in) // R07
    disable iff (!reset_n_in)
    state_q == PREHEAT ##1 state_q == IGNITION |-> $past(preheat_end_s))
    else $error("ignition entered early");

  chk_run_oc_fault: assert property (@(posedge ref_clk_in) // R14
    disable iff (!reset_n_in)
    state_q == RUN && overcurrent_s && !supply_off_s && !bus_trip
      |=> state_q == FAULT && fault_mode_out)
    else $error("run over-current missed");

  chk_fault_outputs: assert property (@(posedge ref_clk_in) // R16
    disable iff (!reset_n_in)
    state_q == FAULT |-> !hs_q && !ls_q && !boost_q && cph_clamp_q)
    else $error("fault outputs not latched low");

  chk_fault_exit: assert property (@(posedge ref_clk_in) // R18
    disable iff (!reset_n_in)
    state_q == FAULT && (supply_off_s || lamp_above_5v_s)
      |=> state_q == SUPPLY_LOCKOUT)
    else $error("fault exit missed");

  chk_bus_under_trip: assert property (@(posedge ref_clk_in) // R20
    disable iff (!reset_n_in)
    is_oscillating(state_q) && bus_trip
      |=> supply_discharge_out && !hs_q && !ls_q)
    else $error("bus undervoltage not acted on");

endmodule // ballast_mode_sequencer

// [test/half_bridge_model.sv]
// timing capacitor model of the power stage side
// assumes gate enables and the timing cap clamp from the sequencer
`timescale 1ns/1ps
module half_bridge_model (
  input  wire logic ref_clk_in,
  input  wire logic high_in,
  input  wire logic low_in,
  input  wire logic clamp_in,
  output logic      upper_out,
  output logic      lower_out
);
  // ****************************************************************
  // cap level: rises while a gate is on, falls in deadtime
  // ****************************************************************
  logic [3:0] level_q = 4'h0;
  always @(posedge ref_clk_in) begin
    if (clamp_in) begin
      level_q <= 4'h0;
    end else if (high_in | low_in) begin
      level_q <= (level_q == 4'hf) ? level_q : level_q + 4'h1;
    end else if (level_q != 4'h0) begin
      level_q <= level_q - 4'h1;
    end
  end
  assign upper_out = (level_q >= 4'h6);
  assign lower_out = (level_q <= 4'h1);
endmodule // half_bridge_model

// [test/ballast_mode_sequencer_tb.sv]
// self-checking bench for the ballast mode sequencer
// assumes half_bridge_model drives the timing cap comparators
`timescale 1ns/1ps
module ballast_mode_sequencer_tb;
  // ****************************************************************
  // clock, stimulus, design
  // ****************************************************************
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
  logic ref_clk_in = 0, reset_n_in = 0, s_on = 0, s_off = 0, l5 = 0;
  logic l3 = 0, l1 = 0, ph_end = 0, run_th = 0, bus_uv = 0, oc = 0;
  logic hs, ls, bst, ctc, phc, src, dis, flt, ct_up, ct_lo;
  logic follow = 0;
  int   num_errors = 0, checked = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  ballast_mode_sequencer ballast_mode_sequencer_inst (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .supply_on_in(s_on), .supply_off_in(s_off),
    .lamp_above_5v_in(l5), .lamp_below_3v_in(l3), .lamp_below_1v_in(l1),
    .preheat_end_threshold_in(ph_end), .run_threshold_in(run_th),
    .bus_undervoltage_threshold_in(bus_uv),
    .overcurrent_threshold_in(oc), .timing_cap_upper_in(ct_up),
    .timing_cap_lower_in(ct_lo), .high_side_gate_out(hs),
    .low_side_gate_out(ls), .boost_switch_gate_out(bst),
    .timing_cap_node_clamp_out(ctc), .preheat_timer_node_clamp_out(phc),
    .preheat_source_enable_out(src), .supply_discharge_out(dis),
    .fault_mode_out(flt));
  half_bridge_model half_bridge_model_inst (.ref_clk_in(ref_clk_in),
    .high_in(hs), .low_in(ls), .clamp_in(ctc), .upper_out(ct_up),
    .lower_out(ct_lo));
  always @(negedge ref_clk_in) if (hs === 1'b1 && ls === 1'b1) `CHK(ls, 0)
  always @(posedge ref_clk_in) if (follow) oc <= hs;
  // ****************************************************************
  // helpers
  // ****************************************************************
  task tick(input int n); repeat (n) @(posedge ref_clk_in); endtask
  task lc(input int n); int k;
    repeat (n) begin
      k = 0;
      while (ls !== 1'b1 && k < 300) begin @(negedge ref_clk_in); k++; end
      while (ls !== 1'b0 && k < 300) begin @(negedge ref_clk_in); k++; end
      `CHK(k < 300, 1'b1)
    end
  endtask
  task wait_ls; int k;
    k = 0;
    while (ls !== 1'b1 && k < 5) begin @(negedge ref_clk_in); k++; end
    `CHK(ls, 1'b1)
    `CHK(hs, 1'b0)
  endtask
  task rearm;
    @(posedge ref_clk_in); l3 <= 0; l5 <= 1; tick(6);
    @(negedge ref_clk_in); `CHK(flt, 1'b0)
    `CHK(ctc, 1'b1)
    @(posedge ref_clk_in); l5 <= 0; l3 <= 1;
    wait_ls;
  endtask
  task to_run; @(posedge ref_clk_in); ph_end <= 1; run_th <= 1; tick(6); endtask
  task fault_check;
    @(negedge ref_clk_in); `CHK(flt, 1'b1)
    `CHK({hs, ls, bst}, 3'h0)
    `CHK(phc, 1'b1)
    @(posedge ref_clk_in); oc <= 0; l1 <= 0; ph_end <= 0; run_th <= 0;
  endtask
  task finish_test;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_lockout;
    @(negedge ref_clk_in); `CHK({hs, ls, ctc, phc, src}, 5'h06)
    @(posedge ref_clk_in); s_on <= 1; tick(10);
    @(negedge ref_clk_in); `CHK({ls, ctc}, 2'h1)
    @(posedge ref_clk_in); l3 <= 1;
    wait_ls;
    `CHK({phc, src, bst}, 3'h3)
  endtask
  task t_alternate; int a, b, d;
    a = 0; b = 0; d = 0;
    while (ls !== 1'b1 && d < 99) begin @(negedge ref_clk_in); d++; end
    d = 0;
    while (ls === 1'b1 && a < 99) begin @(negedge ref_clk_in); a++; end
    while (hs !== 1'b1 && d < 99) begin @(negedge ref_clk_in); d++; end
    while (hs === 1'b1 && b < 99) begin @(negedge ref_clk_in); b++; end
    `CHK(a, b)
    `CHK(d > 1, 1'b1)
  endtask
  task t_high_side_oc;
    follow = 1; lc(110); follow = 0;
    @(posedge ref_clk_in); oc <= 0; lc(2);
    `CHK(flt, 1'b0)
  endtask
  task t_count; int n; logic p;
    @(posedge ref_clk_in); oc <= 1; lc(60);
    @(posedge ref_clk_in); oc <= 0; lc(60);
    @(posedge ref_clk_in); oc <= 1; lc(59);
    `CHK(flt, 1'b0)
    n = 0; p = ls;
    while (flt !== 1'b1 && n < 9000) begin
      @(negedge ref_clk_in); if (p && !ls) n++; p = ls;
    end
    `CHK(n, 41)
    fault_check; tick(20);
    @(negedge ref_clk_in); `CHK(flt, 1'b1)
    rearm;
  endtask
  task t_run;
    to_run; @(posedge ref_clk_in); oc <= 1; tick(5);
    fault_check; rearm;
    for (int i = 0; i < 2; i++) begin
      to_run; @(posedge ref_clk_in);
      if (i == 0) l1 <= 1; else l3 <= 0;
      tick(5);
      @(negedge ref_clk_in); `CHK(flt, 1'b1)
      fault_check; rearm;
    end
  endtask
  task t_bus;
    @(posedge ref_clk_in); bus_uv <= 1; tick(8);
    @(negedge ref_clk_in); `CHK(dis, 1'b0)
    to_run;
    @(negedge ref_clk_in); `CHK({dis, hs, ls, ctc}, 4'h9)
    @(posedge ref_clk_in); s_on <= 0; s_off <= 1; bus_uv <= 0;
    ph_end <= 0; run_th <= 0; tick(6);
    @(negedge ref_clk_in); `CHK({dis, phc}, 2'h1)
    @(posedge ref_clk_in); s_off <= 0; s_on <= 1;
    wait_ls;
  endtask
  initial begin
    tick(4); reset_n_in <= 1;
    t_lockout; lc(2); t_alternate; t_high_side_oc; t_count;
    t_run; t_bus;
    finish_test;
  end
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    num_errors++;
    finish_test;
  end
endmodule // ballast_mode_sequencer_tb
